// >>> src/mixed_sign_multiply_pkg.sv
// Constants for the mixed-sign multiply unit: register offsets, field positions,
// reset values and instruction encodings.
// Assumes a 32-bit APB bus with byte addresses and word-aligned registers.
package mixed_sign_multiply_pkg;

    // ****************************************
    // Register offsets (byte addresses)
    // ****************************************
    localparam logic [7:0] core_control_offset = 8'h00;
    localparam logic [7:0] instruction_offset = 8'h04;
    localparam logic [7:0] status_offset = 8'h08;
    localparam logic [7:0] indirect_data_offset = 8'h0C;
    localparam logic [7:0] acc_a_low_offset = 8'h10;
    localparam logic [7:0] acc_a_high_offset = 8'h14;
    localparam logic [7:0] acc_b_low_offset = 8'h18;
    localparam logic [7:0] acc_b_high_offset = 8'h1C;
    localparam logic [7:0] working_base_offset = 8'h40;

    // ****************************************
    // Register fields and reset values
    // ****************************************
    localparam int integer_fraction_select_bit = 0;
    localparam int multiplier_sign_mode_lsb = 1;
    localparam logic [2:0] core_control_reset = 3'h1;
    localparam int status_illegal_bit = 0;
    localparam int status_pending_bit = 1;

    // ****************************************
    // Instruction encoding
    // ****************************************
    localparam logic [7:0] opcode_signed_base = 8'hB9;
    localparam logic [7:0] opcode_unsigned_base = 8'hB8;
    localparam int opcode_lsb = 16;
    localparam int base_signed_bit = 15;
    localparam int base_lsb = 11;
    localparam int dest_lsb = 7;
    localparam int acc_pattern_lsb = 8;
    localparam logic [2:0] acc_pattern = 3'h7;
    localparam int acc_select_bit = 7;
    localparam int mode_lsb = 4;
    localparam int literal_pattern_lsb = 5;
    localparam logic [1:0] literal_pattern = 2'h3;
    localparam int literal_width = 5;
    localparam logic [3:0] stack_pointer_pair = 4'hE;

    // ****************************************
    // Source addressing modes
    // ****************************************
    localparam logic [2:0] mode_direct = 3'h0;
    localparam logic [2:0] mode_indirect = 3'h1;
    localparam logic [2:0] mode_post_decrement = 3'h2;
    localparam logic [2:0] mode_post_increment = 3'h3;
    localparam logic [2:0] mode_pre_decrement = 3'h4;
    localparam logic [2:0] mode_pre_increment = 3'h5;
    localparam logic [15:0] word_step = 16'h0002;

endpackage : mixed_sign_multiply_pkg

// >>> src/mixed_sign_multiplier.sv
// Combinational 16x16 multiplier whose operands are each signed or unsigned.
// Assumes the caller registers the product; no state is held here.
`timescale 1ns/1ns
module mixed_sign_multiplier (
    input wire logic [15:0] op_a,
    input wire logic [15:0] op_b,
    input wire logic a_signed,
    input wire logic b_signed,
    output logic [31:0] product
);

    logic signed [16:0] wide_a;
    logic signed [16:0] wide_b;
    logic signed [33:0] wide_product;

    // A seventeenth bit lets one signed multiplier serve every sign pairing.
    assign wide_a = $signed({a_signed & op_a[15], op_a});
    assign wide_b = $signed({b_signed & op_b[15], op_b});
    assign wide_product = wide_a * wide_b;
    assign product = wide_product[31:0];

endmodule : mixed_sign_multiplier

// >>> src/mixed_sign_multiply_unit.sv
// Mixed-sign 16x16 multiply datapath with sixteen working registers and two
// 40-bit accumulators, driven by instruction words written over APB.
// Assumes an APB master on pclk; indirect operands are supplied by software.
//
// Behaviour
// - Accumulator forms write 32-bit product to accumulator
// - Accumulator product sign-extended through bit 39
// - Integer or fraction per control register bit
// - Signed-unsigned: base signed, source or literal unsigned
// - Select bit steers product to accumulator A/B
// - Literal forms take 5-bit literal operand
// - Four-bit field picks base working register
// - Decode signed-unsigned short-literal register-pair form
// - Register forms other than signed-signed write product to register pair
// - Multiply completes in one cycle
`timescale 1ns/1ns
module mixed_sign_multiply_unit (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);

    // ****************************************
    // Helpers
    // ****************************************

    // Sign-extends a product into the accumulator, scaling fractions by one bit.
    function automatic logic [39:0] to_accumulator(input logic [31:0] product,
                                                   input logic is_signed,
                                                   input logic integer_mode);
        logic [39:0] extended;
        extended = {{8{is_signed & product[31]}}, product};
        to_accumulator = integer_mode ? extended : {extended[38:0], 1'b0};
    endfunction : to_accumulator

    function automatic logic is_register(input logic [7:0] addr);
        is_register = (addr[7:6] == mixed_sign_multiply_pkg::working_base_offset[7:6]) &&
                      (addr[1:0] == 2'b00);
    endfunction : is_register

    // ****************************************
    // State
    // ****************************************
    logic [2:0] core_control;
    logic [23:0] instruction;
    logic pending;
    logic illegal;
    logic [15:0] indirect_data;
    logic [39:0] accumulator_a;
    logic [39:0] accumulator_b;
    logic [15:0] working [16];

    logic apb_write;
    logic apb_access;
    logic mapped;

    assign apb_access = psel & penable & ~pready;
    assign apb_write = psel & penable & pready & pwrite & ~pslverr;

    // The fixed registers fill every aligned word from offset zero up to the last one.
    assign mapped = is_register(paddr) || (paddr[1:0] == 2'b00 &&
                    paddr <= mixed_sign_multiply_pkg::acc_b_high_offset);

    // ****************************************
    // Decode
    // ****************************************
    typedef enum logic [3:0] {
        op_none = 4'b0001,
        op_signed_unsigned = 4'b0010,
        op_unsigned_signed = 4'b0100,
        op_signed_signed = 4'b1000
    } op_kind_t;

    op_kind_t op_kind;
    logic [3:0] base_index;
    logic [3:0] source_index;
    logic [3:0] dest_index;
    logic [2:0] mode;
    logic to_acc;
    logic use_literal;
    logic select_b;
    logic [15:0] operand_a;
    logic [15:0] operand_b;
    logic [15:0] source_value;
    logic a_signed;
    logic b_signed;
    logic [31:0] product;
    logic decode_illegal;
    logic bad_pair;

    always_comb
    begin
        // Opcodes are word forms only; multiplier_sign_mode is never consulted.
        if (instruction[23:16] == mixed_sign_multiply_pkg::opcode_signed_base)
            op_kind = instruction[mixed_sign_multiply_pkg::base_signed_bit] ?
                      op_signed_signed : op_signed_unsigned;
        else if (instruction[23:16] == mixed_sign_multiply_pkg::opcode_unsigned_base &&
                 instruction[mixed_sign_multiply_pkg::base_signed_bit])
            op_kind = op_unsigned_signed;
        else
            op_kind = op_none;
    end

    assign base_index = instruction[mixed_sign_multiply_pkg::base_lsb +: 4];
    assign dest_index = instruction[mixed_sign_multiply_pkg::dest_lsb +: 4];
    assign source_index = instruction[3:0];
    assign mode = instruction[mixed_sign_multiply_pkg::mode_lsb +: 3];
    assign to_acc = instruction[mixed_sign_multiply_pkg::acc_pattern_lsb +: 3] ==
                    mixed_sign_multiply_pkg::acc_pattern;
    assign select_b = instruction[mixed_sign_multiply_pkg::acc_select_bit];
    assign use_literal = instruction[mixed_sign_multiply_pkg::literal_pattern_lsb +: 2] ==
                         mixed_sign_multiply_pkg::literal_pattern;
    assign bad_pair = dest_index[0] ||
                      dest_index == mixed_sign_multiply_pkg::stack_pointer_pair;

    always_comb
    begin
        unique case (op_kind)
            op_signed_unsigned:
                decode_illegal = !to_acc && bad_pair;
            op_unsigned_signed:
                decode_illegal = use_literal || (!to_acc && bad_pair);
            op_signed_signed:
                decode_illegal = use_literal || !to_acc;
            default:
                decode_illegal = 1'b1;
        endcase
    end

    // Indirect modes fetch nothing from memory; software stages the word beforehand.
    assign source_value = (mode == mixed_sign_multiply_pkg::mode_direct) ?
                          working[source_index] : indirect_data;
    assign operand_a = working[base_index];
    assign operand_b = use_literal ?
                       16'(instruction[mixed_sign_multiply_pkg::literal_width - 1:0]) :
                       source_value;
    assign a_signed = op_kind != op_unsigned_signed;
    assign b_signed = op_kind != op_signed_unsigned;

    mixed_sign_multiplier multiplier (
        .op_a(operand_a),
        .op_b(operand_b),
        .a_signed(a_signed),
        .b_signed(b_signed),
        .product(product)
    );

    logic execute;
    logic [39:0] acc_result;
    logic [15:0] next_source_pointer;
    logic updates_pointer;

    assign execute = pending & ~decode_illegal;
    assign acc_result = to_accumulator(product, a_signed | b_signed,
        core_control[mixed_sign_multiply_pkg::integer_fraction_select_bit]);

    always_comb
    begin
        next_source_pointer = working[source_index];
        updates_pointer = !use_literal;
        unique case (mode)
            mixed_sign_multiply_pkg::mode_post_decrement,
            mixed_sign_multiply_pkg::mode_pre_decrement:
                next_source_pointer = working[source_index] - mixed_sign_multiply_pkg::word_step;
            mixed_sign_multiply_pkg::mode_post_increment,
            mixed_sign_multiply_pkg::mode_pre_increment:
                next_source_pointer = working[source_index] + mixed_sign_multiply_pkg::word_step;
            default:
                updates_pointer = 1'b0;
        endcase
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            core_control <= mixed_sign_multiply_pkg::core_control_reset;
            indirect_data <= 16'h0000;
            instruction <= 24'h00_0000;
        end
        else if (apb_write)
        begin
            if (paddr == mixed_sign_multiply_pkg::core_control_offset)
                core_control <= pwdata[2:0];
            if (paddr == mixed_sign_multiply_pkg::indirect_data_offset)
                indirect_data <= pwdata[15:0];
            if (paddr == mixed_sign_multiply_pkg::instruction_offset)
                instruction <= pwdata[23:0];
        end
    end

    // The multiply runs in the cycle after the instruction word lands.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pending <= 1'b0;
        end
        else
        begin
            pending <= apb_write && paddr == mixed_sign_multiply_pkg::instruction_offset;
        end
    end

    // A new illegal decode wins over a software clear in the same cycle.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            illegal <= 1'b0;
        end
        else if (pending && decode_illegal)
        begin
            illegal <= 1'b1;
        end
        else if (apb_write && paddr == mixed_sign_multiply_pkg::status_offset &&
                 pwdata[mixed_sign_multiply_pkg::status_illegal_bit])
        begin
            illegal <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            accumulator_a <= 40'h00_0000_0000;
            accumulator_b <= 40'h00_0000_0000;
        end
        else if (execute && to_acc)
        begin
            if (select_b)
            begin
                accumulator_b <= acc_result;
            end
            else
            begin
                accumulator_a <= acc_result;
            end
        end
    end

    // Result write goes last so it overrides a pointer update to the same register.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < 16; i++)
            begin
                working[i] <= 16'h0000;
            end
        end
        else if (execute)
        begin
            if (updates_pointer)
            begin
                working[source_index] <= next_source_pointer;
            end
            if (!to_acc)
            begin
                working[dest_index] <= product[15:0];
                working[dest_index + 4'h1] <= product[31:16];
            end
        end
        else if (apb_write && is_register(paddr))
        begin
            working[paddr[5:2]] <= pwdata[15:0];
        end
    end

    // ****************************************
    // APB answer
    // ****************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= apb_access;
            pslverr <= apb_access & ~mapped;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0000_0000;
        end
        else if (apb_access && !pwrite)
        begin
            unique case (paddr)
                mixed_sign_multiply_pkg::core_control_offset:
                    prdata <= {29'h0000_0000, core_control};
                mixed_sign_multiply_pkg::instruction_offset:
                    prdata <= {8'h00, instruction};
                mixed_sign_multiply_pkg::status_offset:
                    prdata <= {30'h0000_0000, pending, illegal};
                mixed_sign_multiply_pkg::indirect_data_offset:
                    prdata <= {16'h0000, indirect_data};
                mixed_sign_multiply_pkg::acc_a_low_offset:
                    prdata <= accumulator_a[31:0];
                mixed_sign_multiply_pkg::acc_a_high_offset:
                    prdata <= {24'h00_0000, accumulator_a[39:32]};
                mixed_sign_multiply_pkg::acc_b_low_offset:
                    prdata <= accumulator_b[31:0];
                mixed_sign_multiply_pkg::acc_b_high_offset:
                    prdata <= {24'h00_0000, accumulator_b[39:32]};
                default:
                    prdata <= is_register(paddr) ? {16'h0000, working[paddr[5:2]]} : 32'h0000_0000;
            endcase
        end
    end

endmodule : mixed_sign_multiply_unit

// >>> bench/mixed_sign_multiply_assertions.sv
// Checker for the mixed-sign multiply unit, watching only its APB ports.
// Assumes one clock domain, pclk, with the asynchronous active-low reset presetn.
`timescale 1ns/1ns
module mixed_sign_multiply_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    logic unmapped;
    logic rd_done;

    // Word registers live at 0x00..0x1C and 0x40..0x7C; all else is refused.
    assign unmapped = (paddr[1:0] != 2'b00) || paddr[7] || (paddr[7:5] == 3'b001);
    assign rd_done = pready && !pwrite;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // ****************************************
    // Assertions
    // ****************************************
    a_ready_timing: assert property ($rose(penable) && psel |=> pready)
        else $error("pready late after access phase");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("pready outside an access phase");
    a_error_decode: assert property (pready |-> pslverr == unmapped)
        else $error("pslverr does not match the address map");
    a_prdata_hold: assert property ($changed(prdata) |-> rd_done)
        else $error("read data changed without a read");
    a_acc_high_byte: assert property (rd_done && !pslverr && (paddr ==
        mixed_sign_multiply_pkg::acc_a_high_offset || paddr ==
        mixed_sign_multiply_pkg::acc_b_high_offset) |-> prdata[31:8] == 24'h00_0000)
        else $error("accumulator top word wider than eight bits");
    a_word_only: assert property (rd_done && paddr[7:6] == 2'b01 && paddr[1:0] == 2'b00
        |-> prdata[31:16] == 16'h0000)
        else $error("working register wider than a word");
    a_no_pending: assert property (rd_done && paddr == mixed_sign_multiply_pkg::status_offset
        |-> prdata[31:1] == 31'h0000_0000)
        else $error("multiply still pending at a status read");
    a_control_width: assert property (rd_done &&
        paddr == mixed_sign_multiply_pkg::core_control_offset
        |-> prdata[31:3] == 29'h0000_0000)
        else $error("control register reads unused bits");

    // ****************************************
    // Coverage
    // ****************************************
    c_acc_read: cover property (rd_done && paddr == mixed_sign_multiply_pkg::acc_b_low_offset);
    c_refused: cover property (pready && pslverr);
    c_issue: cover property (pready && pwrite &&
        paddr == mixed_sign_multiply_pkg::instruction_offset);
endmodule : mixed_sign_multiply_checker

bind mixed_sign_multiply_unit mixed_sign_multiply_checker i_checker (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

// >>> bench/testbench.sv
// Self-checking bench for the mixed-sign multiply unit over APB.
// Assumes the checker is bound to the unit and the package is compiled first.
`timescale 1ns/1ns
module testbench;
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [31:0] rdat;
    logic rerr;
    int err_total;
    int samples_checked;

    mixed_sign_multiply_unit i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));

    // ****************************************
    // Access tasks
    // ****************************************
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : stop_test

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait that never sees pready.
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rc(input logic [7:0] a, input logic [31:0] exp, input string nm);
        apb(1'b0, a, 32'h0000_0000);
        chk(nm, exp, rdat);
        chk("pslverr", 32'h0000_0000, {31'h0000_0000, rerr});
    endtask : rc

    function automatic logic [7:0] wa(input int n);
        return mixed_sign_multiply_pkg::working_base_offset + 8'(4 * n);
    endfunction : wa

    task automatic wreg(input int n, input logic [31:0] v);
        apb(1'b1, wa(n), v);
    endtask : wreg

    task automatic ins(input logic [31:0] v);
        apb(1'b1, mixed_sign_multiply_pkg::instruction_offset, v);
    endtask : ins

    task automatic acc(input logic b, input logic [31:0] lo, input logic [31:0] hi);
        rc(b ? mixed_sign_multiply_pkg::acc_b_low_offset :
            mixed_sign_multiply_pkg::acc_a_low_offset, lo, "acc_low");
        rc(b ? mixed_sign_multiply_pkg::acc_b_high_offset :
            mixed_sign_multiply_pkg::acc_a_high_offset, hi, "acc_high");
    endtask : acc

    // ****************************************
    // Clock, reset and tests
    // ****************************************
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    initial
    begin
        repeat (3000) @(posedge pclk);
        err_total++;
        stop_test;
    end

    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        err_total = 0;
        samples_checked = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rc(mixed_sign_multiply_pkg::core_control_offset, 32'h0000_0001, "ctrl");
        rc(mixed_sign_multiply_pkg::status_offset, 32'h0000_0000, "status");
        acc(1'b0, 32'h0000_0000, 32'h0000_0000);
        wreg(4, 32'h1234_5678);
        rc(wa(4), 32'h0000_5678, "w4");
        // Signed by signed into accumulator A, negative product.
        wreg(0, 32'h0000_9823);
        wreg(1, 32'h0000_67DC);
        ins(32'h00B9_8701);
        acc(1'b0, 32'hD5DC_D314, 32'h0000_00FF);
        // Signed by unsigned, register sources, accumulator A.
        wreg(8, 32'h0000_F000);
        wreg(9, 32'h0000_F000);
        ins(32'h00B9_4709);
        acc(1'b0, 32'hF100_0000, 32'h0000_00FF);
        // Signed by unsigned, indirect source, into the pair W0:W1.
        apb(1'b1, mixed_sign_multiply_pkg::indirect_data_offset, 32'h0000_F000);
        ins(32'h00B9_4019);
        rc(wa(0), 32'h0000_0000, "w0");
        rc(wa(1), 32'h0000_F100, "w1");
        rc(wa(9), 32'h0000_F000, "w9");
        // Signed by short literal 31 into W2:W3.
        wreg(0, 32'h0000_C000);
        ins(32'h00B9_017F);
        rc(wa(2), 32'h0000_4000, "w2");
        rc(wa(3), 32'h0000_FFF8, "w3");
        // Unsigned by signed with post-increment into W10:W11.
        wreg(5, 32'h0000_0C00);
        wreg(6, 32'h0000_FFFF);
        apb(1'b1, mixed_sign_multiply_pkg::indirect_data_offset, 32'h0000_7FFF);
        ins(32'h00B8_B535);
        rc(wa(10), 32'h0000_8001, "w10");
        rc(wa(11), 32'h0000_7FFE, "w11");
        rc(wa(5), 32'h0000_0C02, "w5");
        // Fraction mode with sign mode bits set, literal into accumulator B.
        apb(1'b1, mixed_sign_multiply_pkg::core_control_offset, 32'h0000_0006);
        rc(mixed_sign_multiply_pkg::core_control_offset, 32'h0000_0006, "ctrl");
        wreg(8, 32'h0000_0042);
        ins(32'h00B9_47E2);
        acc(1'b1, 32'h0000_0108, 32'h0000_0000);
        acc(1'b0, 32'hF100_0000, 32'h0000_00FF);
        apb(1'b1, mixed_sign_multiply_pkg::core_control_offset, 32'h0000_0001);
        // Odd destination is refused and leaves the registers alone.
        wreg(3, 32'h0000_1234);
        ins(32'h00B9_0181);
        rc(mixed_sign_multiply_pkg::status_offset, 32'h0000_0001, "status");
        rc(wa(3), 32'h0000_1234, "w3");
        apb(1'b1, mixed_sign_multiply_pkg::status_offset, 32'h0000_0001);
        rc(mixed_sign_multiply_pkg::status_offset, 32'h0000_0000, "status");
        // Signed by signed into a register pair is refused as well.
        ins(32'h00B9_8201);
        rc(mixed_sign_multiply_pkg::status_offset, 32'h0000_0001, "status");
        rc(wa(4), 32'h0000_5678, "w4");
        apb(1'b1, mixed_sign_multiply_pkg::status_offset, 32'h0000_0001);
        // Unmapped places answer with an error and change nothing.
        apb(1'b0, 8'h20, 32'h0000_0000);
        chk("pslverr", 32'h0000_0001, {31'h0000_0000, rerr});
        apb(1'b1, 8'h82, 32'h0000_0000);
        chk("pslverr", 32'h0000_0001, {31'h0000_0000, rerr});
        rc(mixed_sign_multiply_pkg::core_control_offset, 32'h0000_0001, "ctrl");
        stop_test;
    end
endmodule : testbench
